// ==== hsf_status_flags.sv ====
// status flags for high-speed counters 2 and 3 with register port and interrupt
// ==========================================================
// Behaviour
// RULE1: comparison-active flag follows start/stop, cleared at start
// RULE2: overflow/underflow flag set in linear mode
// RULE3: overflow flag cleared on start or pv change
// RULE4: direction from present versus previous pv
// RULE5: direction refreshed per scan and read instruction; the code refreshes it only while cnt_running is set for that counter
// RULE6: eight in-range flags for counter 3
// RULE7: in-range flag independent of interrupt task setup
// RULE8: in-range refreshed on scan, read, init
// RULE9: eight in-range flags for counter 2, low byte
// RULE10: counter 3 direction flag mirrors counter 2
// RULE11: limits themselves count as inside the range
//
// Implementation choice: strobed register access.
module hsf_status_flags (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [hsf_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [hsf_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [hsf_pkg::DATA_W-1:0] reg_rdata,
    input wire logic op_start,
    input wire logic scan_tick,
    input wire logic [hsf_pkg::N_CNT-1:0] cnt_running,
    input wire logic [hsf_pkg::N_CNT-1:0] cnt_linear_mode,
    input wire logic [hsf_pkg::N_CNT-1:0] cmp_start,
    input wire logic [hsf_pkg::N_CNT-1:0] cmp_stop,
    input wire logic [hsf_pkg::N_CNT-1:0] ovf_event,
    input wire logic [hsf_pkg::N_CNT-1:0] pv_load,
    input wire logic [hsf_pkg::N_CNT-1:0] ring_max_load,
    input wire logic [hsf_pkg::N_CNT-1:0] read_counter_instruction,
    input wire logic [hsf_pkg::PV_W-1:0] cnt2_pv,
    input wire logic [hsf_pkg::PV_W-1:0] cnt3_pv,
    output logic irq
);
    localparam int NC = hsf_pkg::N_CNT;
    localparam int NR = hsf_pkg::N_RANGE;
    localparam int PW = hsf_pkg::PV_W;
    localparam int SW = hsf_pkg::STS_W;
    localparam int DW = hsf_pkg::DATA_W;
    localparam int NI = hsf_pkg::N_IRQ;

    // ==========================================================
    // state
    logic [NC-1:0] cmp_active_q;
    logic [NC-1:0] cmp_active_d;
    logic [NC-1:0] ovf_q;
    logic [NC-1:0] ovf_d;
    logic [NC-1:0] dir_q;
    logic [NC-1:0] dir_d;
    logic [PW-1:0] pv_prev_q [NC];
    logic [PW-1:0] pv_prev_d [NC];
    logic [NR-1:0] inrange_q [NC];
    logic [NR-1:0] inrange_d [NC];
    logic [NR-1:0] inrange_calc [NC];
    logic [PW-1:0] lim_q [hsf_pkg::N_LIM];
    logic [NC-1:0] ctrl_q;
    logic [NI-1:0] irq_sts_q;
    logic [NI-1:0] irq_sts_d;
    logic [NI-1:0] irq_mask_q;
    logic [DW-1:0] rdata_q;
    logic irq_q;

    logic [PW-1:0] pv [NC];
    logic [SW-1:0] stw [NC];
    logic [NC-1:0] dir_refresh;
    logic [NC-1:0] range_refresh;
    logic [NC-1:0] range_change_evt;
    logic [NC-1:0] ovf_set_evt;

    assign pv[0] = cnt2_pv;
    assign pv[1] = cnt3_pv;

    // ==========================================================
    // address decode
    logic sel_st2;
    logic sel_st3;
    logic sel_ctrl;
    logic sel_ists;
    logic sel_imask;
    logic sel_lim;
    logic [hsf_pkg::LIM_IDX_W-1:0] lim_idx;
    logic [hsf_pkg::ADDR_W-1:0] lim_off;

    assign sel_st2 = reg_addr == hsf_pkg::OFF_CNT2_STATUS;
    assign sel_st3 = reg_addr == hsf_pkg::OFF_CNT3_STATUS;
    assign sel_ctrl = reg_addr == hsf_pkg::OFF_CTRL;
    assign sel_ists = reg_addr == hsf_pkg::OFF_IRQ_STATUS;
    assign sel_imask = reg_addr == hsf_pkg::OFF_IRQ_MASK;
    assign lim_off = reg_addr - hsf_pkg::OFF_LIMIT_BASE;
    assign sel_lim = (reg_addr >= hsf_pkg::OFF_LIMIT_BASE)
        && (lim_off < hsf_pkg::ADDR_W'(hsf_pkg::N_LIM));
    assign lim_idx = lim_off[hsf_pkg::LIM_IDX_W-1:0];

    // ==========================================================
    // per-counter flags
    for (genvar c = 0; c < NC; c++)
    begin : g_cnt
        // comparison active: start sets, stop or operation start clears
        assign cmp_active_d[c] = op_start ? 1'h0 :
            cmp_start[c] ? 1'h1 :
            cmp_stop[c] ? 1'h0 : cmp_active_q[c]; // RULE1

        // overflow only counts in linear mode; a new event wins over a clear
        assign ovf_set_evt[c] = ovf_event[c] & cnt_linear_mode[c]; // RULE2
        assign ovf_d[c] = ovf_set_evt[c] ? 1'h1 :
            (op_start | pv_load[c]) ? 1'h0 : ovf_q[c]; // RULE3

        // direction: sampled pv against pv of last refresh
        assign dir_refresh[c] = cnt_running[c]
            & (scan_tick | read_counter_instruction[c]); // RULE5
        assign dir_d[c] = !dir_refresh[c] ? dir_q[c] :
            (pv[c] > pv_prev_q[c]) ? 1'h1 :
            (pv[c] < pv_prev_q[c]) ? 1'h0 : dir_q[c]; // RULE4 RULE10
        assign pv_prev_d[c] = dir_refresh[c] ? pv[c] : pv_prev_q[c];

        // in-range compare, both limits inclusive
        for (genvar r = 0; r < NR; r++)
        begin : g_rng
            localparam int LO = c * hsf_pkg::LIM_CNT_STRIDE + r * hsf_pkg::LIM_RANGE_STRIDE;
            assign inrange_calc[c][r] = ctrl_q[c]
                && (pv[c] >= lim_q[LO]) && (pv[c] <= lim_q[LO + 1]); // RULE11 RULE7
        end

        assign range_refresh[c] = scan_tick | read_counter_instruction[c]
            | pv_load[c] | ring_max_load[c]; // RULE8
        assign inrange_d[c] = op_start ? '0 :
            range_refresh[c] ? inrange_calc[c] : inrange_q[c]; // RULE8
        assign range_change_evt[c] = !op_start && range_refresh[c]
            && (inrange_calc[c] != inrange_q[c]);

        // status word: in-range low byte, then cmp, ovf, dir
        assign stw[c] = {{(SW - hsf_pkg::BIT_DIR - 1){1'h0}}, dir_q[c], ovf_q[c],
            cmp_active_q[c], inrange_q[c]}; // RULE6 RULE9

        always_ff @(posedge core_clk)
        begin
            if (sys_rst)
            begin
                pv_prev_q[c] <= '0;
                inrange_q[c] <= '0;
            end
            else
            begin
                pv_prev_q[c] <= pv_prev_d[c];
                inrange_q[c] <= inrange_d[c];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cmp_active_q <= '0;
            ovf_q <= '0;
            dir_q <= '0;
        end
        else
        begin
            cmp_active_q <= cmp_active_d;
            ovf_q <= ovf_d;
            dir_q <= dir_d;
        end
    end

    // ==========================================================
    // software registers
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctrl_q <= hsf_pkg::CTRL_RST;
            irq_mask_q <= hsf_pkg::IRQ_MASK_RST;
        end
        else if (reg_wr)
        begin
            if (sel_ctrl)
                ctrl_q <= reg_wdata[NC-1:0];
            if (sel_imask)
                irq_mask_q <= reg_wdata[NI-1:0];
        end
    end

    for (genvar i = 0; i < hsf_pkg::N_LIM; i++)
    begin : g_lim
        always_ff @(posedge core_clk)
        begin
            if (sys_rst)
                lim_q[i] <= hsf_pkg::LIM_RST;
            else if (reg_wr && sel_lim && (lim_idx == hsf_pkg::LIM_IDX_W'(i)))
                lim_q[i] <= reg_wdata[PW-1:0];
        end
    end

    // ==========================================================
    // interrupt: sticky, cleared by a read, new events win
    logic [NI-1:0] irq_evt;
    logic ists_rd;

    assign irq_evt = {range_change_evt, ovf_set_evt};
    assign ists_rd = reg_rd & sel_ists;
    assign irq_sts_d = irq_evt | (ists_rd ? '0 : irq_sts_q);

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            irq_sts_q <= '0;
            irq_q <= 1'h0;
        end
        else
        begin
            irq_sts_q <= irq_sts_d;
            irq_q <= |(irq_sts_d & irq_mask_q);
        end
    end

    // ==========================================================
    // read data, valid the cycle after the strobe only
    logic [DW-1:0] rd_mux;

    assign rd_mux = sel_st2 ? DW'(stw[0]) :
        sel_st3 ? DW'(stw[1]) :
        sel_ctrl ? DW'(ctrl_q) :
        sel_ists ? DW'(irq_sts_q) :
        sel_imask ? DW'(irq_mask_q) :
        sel_lim ? DW'(lim_q[lim_idx]) : hsf_pkg::RDATA_RST;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            rdata_q <= hsf_pkg::RDATA_RST;
        else
            rdata_q <= reg_rd ? rd_mux : hsf_pkg::RDATA_RST;
    end

    assign reg_rdata = rdata_q;
    assign irq = irq_q;
endmodule

// ==== hsf_pkg.sv ====
// constants for the high-speed counter status-flag block
package hsf_pkg;
    // ==========================================================
    // widths
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int PV_W = 32;
    localparam int STS_W = 16;
    localparam int N_CNT = 2;
    localparam int N_RANGE = 8;
    localparam int N_LIM = 32;
    localparam int LIM_IDX_W = 5;
    localparam int N_IRQ = 4;
    // ==========================================================
    // register word addresses
    localparam logic [ADDR_W-1:0] OFF_CNT2_STATUS = 10'h140;
    localparam logic [ADDR_W-1:0] OFF_CNT3_STATUS = 10'h141;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 10'h150;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 10'h151;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 10'h152;
    // limit window: 0x160 + counter*16 + range*2 + (0 lower, 1 upper)
    localparam logic [ADDR_W-1:0] OFF_LIMIT_BASE = 10'h160;
    localparam int LIM_CNT_STRIDE = 16;
    localparam int LIM_RANGE_STRIDE = 2;
    // ==========================================================
    // status word fields
    localparam int BIT_INRANGE_LSB = 0;
    localparam int BIT_CMP_ACTIVE = 8;
    localparam int BIT_OVF = 9;
    localparam int BIT_DIR = 10;
    // ==========================================================
    // interrupt status bits: ovf of counter c at c, range change at c+N_CNT
    localparam int IRQ_OVF_LSB = 0;
    localparam int IRQ_RANGE_LSB = 2;
    // ==========================================================
    // reset values
    localparam logic [N_CNT-1:0] CTRL_RST = 2'h0;
    localparam logic [N_IRQ-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [PV_W-1:0] LIM_RST = 32'h00000000;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;
endpackage

// ==== hsf_checker.sv ====
// port assertions for the counter status-flag block
module hsf_checker (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [9:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic op_start,
    input wire logic [1:0] cnt_linear_mode,
    input wire logic [1:0] cmp_start,
    input wire logic [1:0] cmp_stop,
    input wire logic [1:0] ovf_event,
    input wire logic [1:0] pv_load
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd2; reg_rd && reg_addr == 10'h140; endsequence
    sequence s_rd3; reg_rd && reg_addr == 10'h141; endsequence
    property p_idle; !$past(reg_rd) |-> reg_rdata == '0; endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    property p_unmap; reg_rd && reg_addr == 10'h3FF |=> reg_rdata == '0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_upper; s_rd2 |=> reg_rdata[31:11] == '0; endproperty
    a_upper: assert property (p_upper) else $error("unused status bits set");
    property p_cmp_on; cmp_start[0] && !cmp_stop[0] && !op_start ##1 s_rd2 |=> reg_rdata[8];
    endproperty
    a_cmp_on: assert property (p_cmp_on) else $error("compare flag not set");
    property p_cmp_off; cmp_stop[1] && !cmp_start[1] ##1 s_rd3 |=> !reg_rdata[8]; endproperty
    a_cmp_off: assert property (p_cmp_off) else $error("compare flag not clear");
    property p_start; op_start && !ovf_event[0] ##1 s_rd2 |=> reg_rdata[9:0] == '0; endproperty
    a_start: assert property (p_start) else $error("start did not clear");
    property p_ovf; ovf_event[0] && cnt_linear_mode[0] ##1 !pv_load[0] && !op_start ##1 s_rd2
        |=> reg_rdata[9]; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");
    property p_pv; pv_load[0] && !ovf_event[0] ##1 s_rd2 |=> !reg_rdata[9]; endproperty
    a_pv: assert property (p_pv) else $error("overflow flag not cleared");
endmodule

bind hsf_status_flags hsf_checker u_chk (.*);

// ==== hsf_host.sv ====
// register-port master standing in for the user program
module hsf_host (
    input wire logic core_clk,
    output logic [9:0] reg_addr,
    output logic [31:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        reg_wdata <= ~d;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        reg_addr <= ~a;
        @(posedge core_clk);
        d = reg_rdata;
    endtask
endmodule

// ==== tb.sv ====
// self-checking bench for the counter status-flag block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = '0, sys_rst = 1'h1, op_start = '0, scan_tick = '0, irq;
    logic [1:0] cnt_running = '0, cnt_linear_mode = '0, cmp_start = '0, cmp_stop = '0;
    logic [1:0] ovf_event = '0, pv_load = '0, ring_max_load = '0, read_counter_instruction = '0;
    logic [31:0] cnt2_pv = '0, cnt3_pv = '0, reg_wdata, reg_rdata;
    logic [9:0] reg_addr;
    logic reg_wr, reg_rd;
    int fail_count = 0, check_count = 0;
    hsf_status_flags u_dut (.*);
    hsf_host u_host (.*);
    initial forever #2.5 core_clk = ~core_clk;
    task automatic tick;
        @(posedge core_clk);
    endtask
    task automatic same(input string n, input logic [31:0] e, input logic [31:0] v);
        check_count++;
        if (v !== e)
        begin
            $display("BAD %s exp %h got %h", n, e, v);
            fail_count++;
        end
    endtask
    task automatic chk(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] v;
        u_host.rd(a, v);
        same($sformatf("word %h", a), e, v & m);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge core_clk);
        fail_count++;
        complete_run;
    end
    initial
    begin
        repeat (2) tick;
        sys_rst <= 1'h0;
        tick;
        chk(10'h140, '1, '0);
        chk(10'h141, '1, '0);
        chk(10'h3FF, '1, '0);
        // range r spans r*20 to r*20+19 on both counters
        for (int i = 0; i < 32; i++)
            u_host.wr(10'(10'h160 + i), 32'((i % 16) / 2 * 20 + (i % 2) * 19));
        u_host.wr(10'h150, 32'h3);
        u_host.wr(10'h140, '1);
        cnt_running <= 2'h3;
        cnt_linear_mode <= 2'h3;
        cnt2_pv <= 32'h64;
        cnt3_pv <= 32'h27;
        scan_tick <= 1'h1;
        tick;
        scan_tick <= 1'h0;
        chk(10'h140, '1, 32'h420);
        chk(10'h141, '1, 32'h402);
        same("irq", '0, 32'(irq));
        cnt2_pv <= 32'h78;
        cnt3_pv <= 32'h13;
        read_counter_instruction <= 2'h1;
        pv_load <= 2'h2;
        tick;
        read_counter_instruction <= 2'h2;
        pv_load <= 2'h0;
        tick;
        read_counter_instruction <= 2'h0;
        chk(10'h140, '1, 32'h440);
        chk(10'h141, '1, 32'h001);
        cnt3_pv <= 32'h27;
        ring_max_load <= 2'h2;
        tick;
        ring_max_load <= 2'h0;
        chk(10'h141, 32'hFF, 32'h02);
        cmp_start <= 2'h3;
        tick;
        cmp_start <= 2'h0;
        chk(10'h140, 32'h100, 32'h100);
        cmp_stop <= 2'h2;
        tick;
        cmp_stop <= 2'h0;
        chk(10'h141, 32'h100, '0);
        u_host.wr(10'h152, 32'h1);
        ovf_event <= 2'h3;
        tick;
        ovf_event <= 2'h0;
        tick;
        same("irq", 32'h1, 32'(irq));
        chk(10'h140, 32'h200, 32'h200);
        chk(10'h151, 32'h3, 32'h3);
        same("irq", '0, 32'(irq));
        pv_load <= 2'h1;
        tick;
        pv_load <= 2'h0;
        chk(10'h140, 32'h200, '0);
        cnt_linear_mode <= 2'h0;
        ovf_event <= 2'h1;
        tick;
        ovf_event <= 2'h0;
        chk(10'h140, 32'h200, '0);
        op_start <= 1'h1;
        tick;
        op_start <= 1'h0;
        chk(10'h140, 32'h3FF, '0);
        chk(10'h141, 32'h3FF, '0);
        chk(10'h140, 32'h400, 32'h400);
        sys_rst <= 1'h1;
        repeat (2) tick;
        sys_rst <= 1'h0;
        tick;
        chk(10'h140, '1, '0);
        chk(10'h150, '1, '0);
        chk(10'h152, '1, '0);
        chk(10'h161, '1, '0);
        same("irq", '0, 32'(irq));
        complete_run;
    end
endmodule
